// ===== sli_led_panel.sv
`timescale 1ns/1ps
`default_nettype none
module sli_led_panel (
  // Lamp drives from the block
  input wire logic solar_white_i,
  input wire logic battery_white_i,
  input wire logic err_yellow_i,
  input wire logic err_red_i,
  input wire logic bk_white_i,
  input wire logic bk_red_i,
  input wire logic grid_white_i,
  input wire logic grid_red_i,
  // Lit lamps, in lamp state register order
  output logic [7:0] lit_o
);
  // Bare LEDs: a lamp is lit exactly while its drive is high
  assign lit_o = {grid_red_i, grid_white_i, bk_red_i, bk_white_i,
    err_red_i, err_yellow_i, battery_white_i, solar_white_i};
endmodule // sli_led_panel
`default_nettype wire

// ===== sli_pkg.sv
`default_nettype none
package sli_pkg;
  // Clock and blink timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
  // Photovoltaic channel sensing, current in milliamps
  localparam int unsigned PV_CH = 2;
  localparam int unsigned PV_CUR_W = 16;
  localparam logic [15:0] PV_THR_MA = 16'h01f4;
  // Register map, byte addresses
  localparam logic [3:0] REG_BLINK = 4'h0;
  localparam logic [3:0] REG_LAMPS = 4'h4;
  localparam logic [3:0] REG_COND = 4'h8;
  // Lamp state field positions in REG_LAMPS
  localparam int unsigned LB_SOLAR_W = 0;
  localparam int unsigned LB_BATTERY_W = 1;
  localparam int unsigned LB_ERR_Y = 2;
  localparam int unsigned LB_ERR_R = 3;
  localparam int unsigned LB_BK_W = 4;
  localparam int unsigned LB_BK_R = 5;
  localparam int unsigned LB_GRID_W = 6;
  localparam int unsigned LB_GRID_R = 7;
  localparam int unsigned LB_PHASE = 8;
  // Lamp modes
  typedef enum logic [2:0] {
    LM_OFF = 3'b001,
    LM_ON = 3'b010,
    LM_BLINK = 3'b100
  } sli_mode_t;
endpackage
`default_nettype wire

// ===== sli_status_led.sv
// Operation
// - Five lamps: solar, battery white; error yellow/red; backup, grid white/red
// - Solar steady white when any PV channel current exceeds 0.5 A
// - Solar blinks white during self-check or software update
// - Solar dark when PV idle and no self-check or update
// - Battery steady white when at least one battery works normally
// - Battery blinks white on self-check, update or low charge
// - Battery dark when no battery works and no blink reason
// - Error steady yellow when cloud link is abnormal
// - Error blinks yellow while a warning is active
// - Error steady red while the unit is faulty
// - Error dark with no fault, warning or cloud problem
// - Backup steady white when output normal with load
// - Backup blinks white when output normal without load
// - Backup steady red on backup output fault
// - Backup blinks red on backup output overload
// - Backup dark when backup output has no voltage
// - Grid steady white when grid present and unit connected
// - Grid blinks white when grid present but forced off-grid
// - Grid steady red on grid fault
// - Grid dark when the unit is shut down
`timescale 1ns/1ps
`default_nettype none
module sli_status_led
  import sli_pkg::*;
#(
  parameter logic [31:0] BLINK_HALF_DEF = BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Controller status flags
  input wire logic [PV_CH*PV_CUR_W-1:0] pv_cur_ma_i,
  input wire logic self_check_i,
  input wire logic sw_update_i,
  input wire logic battery_ok_i,
  input wire logic soc_low_i,
  input wire logic cloud_fault_i,
  input wire logic warning_i,
  input wire logic unit_fault_i,
  input wire logic bk_volt_i,
  input wire logic bk_load_i,
  input wire logic bk_fault_i,
  input wire logic bk_ovld_i,
  input wire logic grid_present_i,
  input wire logic grid_conn_i,
  input wire logic forced_offgrid_i,
  input wire logic grid_fault_i,
  input wire logic unit_shutdown_i,
  // Lamp drives, active high
  output logic solar_white_o,
  output logic battery_indicator_white_o,
  output logic err_yellow_o,
  output logic err_red_o,
  output logic backup_output_indicator_white_o,
  output logic backup_output_indicator_red_o,
  output logic grid_white_o,
  output logic grid_red_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] blink_half_r;
  logic [31:0] blink_cnt_r;
  logic [31:0] blink_cnt_nxt;
  logic blink_ph_r;
  logic [31:0] half_eff;
  logic [PV_CH-1:0] pv_act;
  logic pv_any;
  logic wb_req;
  sli_mode_t solar_m, battery_m, err_y_m, err_r_m;
  sli_mode_t bk_w_m, bk_r_m, grid_w_m, grid_r_m;
  logic [31:0] lamps;
  logic [31:0] conds;

  function automatic logic lit(input sli_mode_t m, input logic ph);
    lit = (m == LM_ON) || ((m == LM_BLINK) && ph);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Blink prescaler
  // Zero period would stall the counter, so it acts as one
  assign half_eff = (blink_half_r == 32'h0) ? 32'h1 : blink_half_r;

  always_comb begin
    if (blink_cnt_r >= half_eff - 32'h1) begin
      blink_cnt_nxt = 32'h0;
    end else begin
      blink_cnt_nxt = blink_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_r <= 32'h0;
      blink_ph_r <= 1'b0;
    end else begin
      blink_cnt_r <= blink_cnt_nxt;
      if (blink_cnt_nxt == 32'h0) begin
        blink_ph_r <= ~blink_ph_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Photovoltaic activity per channel
  for (genvar c = 0; c < PV_CH; c++) begin : g_pv
    assign pv_act[c] = pv_cur_ma_i[c*PV_CUR_W +: PV_CUR_W] > PV_THR_MA;
  end
  assign pv_any = |pv_act;

  ////////////////////////////////////////////////////////////////////////////
  // Lamp mode selection; blink reasons override steady white on solar and
  // battery so that an update stays visible
  always_comb begin
    if (self_check_i || sw_update_i) begin
      solar_m = LM_BLINK;
    end else if (pv_any) begin
      solar_m = LM_ON;
    end else begin
      solar_m = LM_OFF;
    end
    if (self_check_i || sw_update_i || soc_low_i) begin
      battery_m = LM_BLINK;
    end else if (battery_ok_i) begin
      battery_m = LM_ON;
    end else begin
      battery_m = LM_OFF;
    end
  end

  always_comb begin
    err_r_m = LM_OFF;
    err_y_m = LM_OFF;
    if (unit_fault_i) begin
      err_r_m = LM_ON;
    end else if (cloud_fault_i) begin
      err_y_m = LM_ON;
    end else if (warning_i) begin
      err_y_m = LM_BLINK;
    end
  end

  always_comb begin
    bk_r_m = LM_OFF;
    bk_w_m = LM_OFF;
    if (bk_fault_i) begin
      bk_r_m = LM_ON;
    end else if (bk_ovld_i) begin
      bk_r_m = LM_BLINK;
    end else if (!bk_volt_i) begin
      bk_w_m = LM_OFF;
    end else if (bk_load_i) begin
      bk_w_m = LM_ON;
    end else begin
      bk_w_m = LM_BLINK;
    end
  end

  always_comb begin
    grid_r_m = LM_OFF;
    grid_w_m = LM_OFF;
    if (grid_fault_i) begin
      grid_r_m = LM_ON;
    end else if (unit_shutdown_i || !grid_present_i) begin
      grid_w_m = LM_OFF;
    end else if (grid_conn_i && !forced_offgrid_i) begin
      grid_w_m = LM_ON;
    end else if (forced_offgrid_i) begin
      grid_w_m = LM_BLINK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp drive flops, one colour lit at a time per lamp
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      solar_white_o <= 1'b0;
      battery_indicator_white_o <= 1'b0;
      err_yellow_o <= 1'b0;
      err_red_o <= 1'b0;
      backup_output_indicator_white_o <= 1'b0;
      backup_output_indicator_red_o <= 1'b0;
      grid_white_o <= 1'b0;
      grid_red_o <= 1'b0;
    end else begin
      solar_white_o <= lit(solar_m, blink_ph_r);
      battery_indicator_white_o <= lit(battery_m, blink_ph_r);
      err_yellow_o <= lit(err_y_m, blink_ph_r);
      err_red_o <= lit(err_r_m, blink_ph_r);
      backup_output_indicator_white_o <= lit(bk_w_m, blink_ph_r);
      backup_output_indicator_red_o <= lit(bk_r_m, blink_ph_r);
      grid_white_o <= lit(grid_w_m, blink_ph_r);
      grid_red_o <= lit(grid_r_m, blink_ph_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state, unmapped reads return zero
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Field positions shared with software, unused bits read zero
  always_comb begin
    lamps = 32'h0;
    lamps[LB_SOLAR_W] = solar_white_o;
    lamps[LB_BATTERY_W] = battery_indicator_white_o;
    lamps[LB_ERR_Y] = err_yellow_o;
    lamps[LB_ERR_R] = err_red_o;
    lamps[LB_BK_W] = backup_output_indicator_white_o;
    lamps[LB_BK_R] = backup_output_indicator_red_o;
    lamps[LB_GRID_W] = grid_white_o;
    lamps[LB_GRID_R] = grid_red_o;
    lamps[LB_PHASE] = blink_ph_r;
  end

  assign conds = {15'h0, unit_shutdown_i, grid_fault_i, forced_offgrid_i,
                  grid_conn_i, grid_present_i, bk_ovld_i, bk_fault_i,
                  bk_load_i, bk_volt_i, unit_fault_i, warning_i,
                  cloud_fault_i, soc_low_i, battery_ok_i, sw_update_i,
                  self_check_i, pv_any};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_BLINK: wb_dat_o <= blink_half_r;
        REG_LAMPS: wb_dat_o <= lamps;
        REG_COND: wb_dat_o <= conds;
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  for (genvar b = 0; b < 4; b++) begin : g_lane
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        blink_half_r[b*8 +: 8] <= BLINK_HALF_DEF[b*8 +: 8];
      end else if (wb_req && wb_we_i && wb_sel_i[b] &&
                   (wb_adr_i == REG_BLINK)) begin
        blink_half_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_solar_steady: assert property (
    pv_any && !self_check_i && !sw_update_i |=> solar_white_o)
    else $error("solar not steady with PV active");
  a_solar_blink: assert property (
    self_check_i || sw_update_i |=> solar_white_o == $past(blink_ph_r))
    else $error("solar not blinking on self-check");
  a_solar_dark: assert property (
    !pv_any && !self_check_i && !sw_update_i |=> !solar_white_o)
    else $error("solar lit while idle");
  a_battery_steady: assert property (
    battery_ok_i && !self_check_i && !sw_update_i && !soc_low_i
    |=> battery_indicator_white_o)
    else $error("battery not steady");
  a_battery_blink: assert property (
    soc_low_i |=> battery_indicator_white_o == $past(blink_ph_r))
    else $error("battery not blinking on low charge");
  a_battery_dark: assert property (
    !battery_ok_i && !self_check_i && !sw_update_i && !soc_low_i
    |=> !battery_indicator_white_o)
    else $error("battery lit while idle");
  a_err_cloud: assert property (
    cloud_fault_i && !unit_fault_i |=> err_yellow_o && !err_red_o)
    else $error("cloud fault not yellow");
  a_err_warn: assert property (
    warning_i && !cloud_fault_i && !unit_fault_i
    |=> err_yellow_o == $past(blink_ph_r))
    else $error("warning not blinking yellow");
  a_err_fault: assert property (
    unit_fault_i |=> err_red_o && !err_yellow_o)
    else $error("fault not steady red");
  a_err_dark: assert property (
    !unit_fault_i && !cloud_fault_i && !warning_i
    |=> !err_red_o && !err_yellow_o)
    else $error("error lamp lit in normal work");
  a_bk_load: assert property (
    bk_volt_i && bk_load_i && !bk_fault_i && !bk_ovld_i
    |=> backup_output_indicator_white_o && !backup_output_indicator_red_o)
    else $error("backup not steady white");
  a_bk_noload: assert property (
    bk_volt_i && !bk_load_i && !bk_fault_i && !bk_ovld_i
    |=> backup_output_indicator_white_o == $past(blink_ph_r))
    else $error("backup not blinking white");
  a_bk_fault: assert property (
    bk_fault_i |=> backup_output_indicator_red_o &&
    !backup_output_indicator_white_o)
    else $error("backup fault not red");
  a_bk_ovld: assert property (
    bk_ovld_i && !bk_fault_i
    |=> backup_output_indicator_red_o == $past(blink_ph_r))
    else $error("overload not blinking red");
  a_bk_dark: assert property (
    !bk_volt_i && !bk_fault_i && !bk_ovld_i
    |=> !backup_output_indicator_white_o && !backup_output_indicator_red_o)
    else $error("backup lit without voltage");
  a_grid_on: assert property (
    grid_present_i && grid_conn_i && !forced_offgrid_i && !grid_fault_i &&
    !unit_shutdown_i |=> grid_white_o && !grid_red_o)
    else $error("grid not steady white");
  a_grid_off: assert property (
    grid_present_i && forced_offgrid_i && !grid_fault_i && !unit_shutdown_i
    |=> grid_white_o == $past(blink_ph_r))
    else $error("forced off-grid not blinking");
  a_grid_fault: assert property (
    grid_fault_i |=> grid_red_o && !grid_white_o)
    else $error("grid fault not red");
  a_grid_dark: assert property (
    unit_shutdown_i && !grid_fault_i |=> !grid_white_o && !grid_red_o)
    else $error("grid lit during shutdown");
  a_blink_rate: assert property (
    blink_ph_r != $past(blink_ph_r) |-> blink_cnt_r == 32'h0)
    else $error("phase toggled off the period boundary");
  a_one_colour: assert property (
    !(err_red_o && err_yellow_o) && !(grid_red_o && grid_white_o))
    else $error("two colours lit on one lamp");
  a_bus_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge timing wrong");
  a_bk_colour: assert property (
    !(backup_output_indicator_red_o && backup_output_indicator_white_o))
    else $error("two colours lit on backup lamp");
  a_blink_hold: assert property (
    blink_cnt_r != 32'h0 |-> blink_ph_r == $past(blink_ph_r))
    else $error("phase toggled inside a half period");
  a_blink_write: assert property (
    wb_req && wb_we_i && (wb_adr_i == REG_BLINK) && (wb_sel_i == 4'hf)
    |=> blink_half_r == $past(wb_dat_i))
    else $error("blink period write lost");
  a_bus_read: assert property (
    wb_req && !wb_we_i && (wb_adr_i == REG_BLINK)
    |=> wb_dat_o == $past(blink_half_r))
    else $error("blink period read wrong");
  a_bus_unmapped: assert property (
    wb_req && !wb_we_i && (wb_adr_i != REG_BLINK) &&
    (wb_adr_i != REG_LAMPS) && (wb_adr_i != REG_COND) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Grid absent darkens the lamp as shutdown does, even when forced off-grid
  a_grid_absent: assert property (
    !grid_present_i && !grid_fault_i |=> !grid_white_o && !grid_red_o)
    else $error("grid lamp lit while grid absent");

  c_phase_flip: cover property (blink_ph_r ##1 !blink_ph_r);
  c_bk_overload: cover property (bk_ovld_i ##1 backup_output_indicator_red_o);
  c_grid_blink: cover property (forced_offgrid_i && grid_present_i);
  c_bus_write: cover property (wb_req && wb_we_i);

endmodule // sli_status_led
`default_nettype wire

// ===== sli_status_led_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module sli_status_led_test;
  import sli_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, rd, pv = 32'h0;
  logic [15:0] flg = 16'h0;
  logic [7:0] lw, lit;
  int bad_count = 0;
  int compares = 0;
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // Short blink half-period keeps each blink check to a few cycles
  sli_status_led #(.BLINK_HALF_DEF(32'h4)) u_sli_status_led (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pv_cur_ma_i(pv),
    .self_check_i(flg[0]), .sw_update_i(flg[1]), .battery_ok_i(flg[2]),
    .soc_low_i(flg[3]), .cloud_fault_i(flg[4]), .warning_i(flg[5]),
    .unit_fault_i(flg[6]), .bk_volt_i(flg[7]), .bk_load_i(flg[8]),
    .bk_fault_i(flg[9]), .bk_ovld_i(flg[10]), .grid_present_i(flg[11]),
    .grid_conn_i(flg[12]), .forced_offgrid_i(flg[13]),
    .grid_fault_i(flg[14]), .unit_shutdown_i(flg[15]),
    .solar_white_o(lw[0]), .battery_indicator_white_o(lw[1]),
    .err_yellow_o(lw[2]), .err_red_o(lw[3]),
    .backup_output_indicator_white_o(lw[4]),
    .backup_output_indicator_red_o(lw[5]),
    .grid_white_o(lw[6]), .grid_red_o(lw[7]));
  sli_led_panel u_sli_led_panel (
    .solar_white_i(lw[0]), .battery_white_i(lw[1]), .err_yellow_i(lw[2]),
    .err_red_i(lw[3]), .bk_white_i(lw[4]), .bk_red_i(lw[5]),
    .grid_white_i(lw[6]), .grid_red_i(lw[7]), .lit_o(lit));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One classic cycle; request held until ack is sampled
  task automatic xfer(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (ack !== 1'b1) begin
      `CHK(ack, 1'b1)
      results();
    end
  endtask
  // Steady lamps must never drop; blinking ones toggle tg times in 16
  task automatic lamps(input logic [7:0] st, input logic [7:0] bl,
      input int tg);
    logic [7:0] a, o, p;
    int c [8];
    repeat (3) @(posedge clk_i);
    a = lit; o = lit; p = lit; c = '{default: 0};
    repeat (16) begin
      @(posedge clk_i);
      a &= lit; o |= lit;
      for (int i = 0; i < 8; i++) if (lit[i] !== p[i]) c[i]++;
      p = lit;
    end
    `CHK(a, st)
    `CHK(o, st | bl)
    for (int i = 0; i < 8; i++) if (bl[i]) `CHK(c[i], tg)
  endtask
  task automatic scen(input logic [31:0] p, input logic [15:0] f,
      input logic [7:0] st, input logic [7:0] bl);
    logic any;
    @(posedge clk_i);
    pv <= p; flg <= f;
    lamps(st, bl, 4);
    any = (p[15:0] > PV_THR_MA) || (p[31:16] > PV_THR_MA);
    xfer(1'b0, REG_COND, 32'h0, 4'hf);
    `CHK(rd, {15'h0, f, any})
    // Blinking lamps may read either way, steady ones must match
    xfer(1'b0, REG_LAMPS, 32'h0, 4'hf);
    `CHK(rd[7:0] & ~bl, st)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    xfer(1'b0, REG_BLINK, 32'h0, 4'hf);
    `CHK(rd, 32'h4)
    xfer(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(rd, 32'h0)
    xfer(1'b1, REG_LAMPS, 32'hff, 4'hf);
    xfer(1'b0, REG_LAMPS, 32'h0, 4'hf);
    `CHK(rd[7:0], 8'h00)
    $display("register test done");
  endtask
  task automatic t_solar();
    scen(32'h0000_01f4, 16'h0000, 8'h00, 8'h00);
    scen(32'h01f5_0000, 16'h0000, 8'h01, 8'h00);
    scen(32'h01f5_0000, 16'h0001, 8'h00, 8'h03);
    scen(32'h0000_0000, 16'h0002, 8'h00, 8'h03);
    $display("solar test done");
  endtask
  task automatic t_battery();
    scen(32'h0, 16'h0004, 8'h02, 8'h00);
    scen(32'h0, 16'h000c, 8'h00, 8'h02);
    scen(32'h0, 16'h0000, 8'h00, 8'h00);
    $display("battery test done");
  endtask
  task automatic t_error();
    scen(32'h0, 16'h0010, 8'h04, 8'h00);
    scen(32'h0, 16'h0020, 8'h00, 8'h04);
    scen(32'h0, 16'h0030, 8'h04, 8'h00);
    scen(32'h0, 16'h0070, 8'h08, 8'h00);
    $display("error test done");
  endtask
  task automatic t_backup();
    scen(32'h0, 16'h0180, 8'h10, 8'h00);
    scen(32'h0, 16'h0080, 8'h00, 8'h10);
    scen(32'h0, 16'h0680, 8'h20, 8'h00);
    scen(32'h0, 16'h0480, 8'h00, 8'h20);
    scen(32'h0, 16'h0100, 8'h00, 8'h00);
    $display("backup test done");
  endtask
  task automatic t_grid();
    scen(32'h0, 16'h1800, 8'h40, 8'h00);
    scen(32'h0, 16'h3800, 8'h00, 8'h40);
    scen(32'h0, 16'hd800, 8'h80, 8'h00);
    scen(32'h0, 16'h9800, 8'h00, 8'h00);
    $display("grid test done");
  endtask
  task automatic t_rate();
    xfer(1'b1, REG_BLINK, 32'h2, 4'h1);
    xfer(1'b1, REG_BLINK, 32'h7, 4'h0);
    xfer(1'b0, REG_BLINK, 32'h0, 4'hf);
    `CHK(rd, 32'h2)
    @(posedge clk_i);
    flg <= 16'h0001;
    lamps(8'h00, 8'h03, 8);
    xfer(1'b1, REG_BLINK, 32'h4, 4'hf);
    $display("rate test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_solar();
    t_battery();
    t_error();
    t_backup();
    t_grid();
    t_rate();
    results();
  end
endmodule // sli_status_led_test
`default_nettype wire
